// [core/rrpo_pkg.sv]
// rrpo_pkg: constants, offsets and types for the read result pulse outputs
// Notes on behaviour
// (RL1) three independent outputs, each with own selection, idle level, on and off time
// (RL2) at read cycle end, a selected output pulses on, then stays off
// (RL3) read cycle not finished until on plus off time has elapsed
// (RL4) idle level per output, normally open default, activation drives opposite level
// (RL5) output fires when any of its enabled conditions is true
// (RL6) defaults: output 1 pass, output 2 fail, output 3 error
// (RL7) on time in microseconds, 0 to 10,000,000, default 1000
// (RL8) off time in microseconds, 0 to 10,000,000, default 1000
// (RL9) only pulsed mode exists
// (RL10) cycle-complete fires only after result data is sent, off by default
// (RL11) pass: all found, correct type, read and matched; on by default
// (RL12) fail: any code missing, wrong type, unread or unmatched; on by default
// (RL13) error: trigger overrun, processing overrun or general fault in the cycle
// (RL14) all-present: every region found a code of correct type
// (RL15) all-read: found codes also passed content qualification
// (RL16) all-match: present and qualified codes also passed string matching
// (RL17) not-all-present: at least one target code not found
// (RL18) not-all-read: at least one found code failed qualification
// (RL19) not-all-match: at least one found and qualified code failed matching
// (RL20) trigger overrun: new trigger before previous acquisition completed
// (RL21) processing overrun: trigger while image buffers are exhausted
// (RL22) good quality: every verification-enabled region passed verification; the code checks only those that also passed qualification
// (RL23) matching disabled and decode passes counts as all-match
// (RL24) after reset outputs idle, no pulse, until first read cycle ends
// (RL25) intervals timed by a one microsecond tick from the system clock
package rrpo_pkg;
    // ***********************************
    // sizes and timing
    // ***********************************
    localparam int NUM_OUT = 3;
    localparam int NUM_COND = 13;
    localparam int TIME_W = 24;
    localparam int CLK_MHZ = 125;
    localparam int TICK_US = 1;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam logic [TIME_W-1:0] TIME_MAX_US = 24'h98_9680;
    localparam logic [TIME_W-1:0] TIME_DEF_US = 24'h00_03E8;
    // ***********************************
    // condition bit positions
    // ***********************************
    localparam int C_COMPLETE = 0;
    localparam int C_PASS = 1;
    localparam int C_FAIL = 2;
    localparam int C_ERROR = 3;
    localparam int C_PRESENT = 4;
    localparam int C_READ = 5;
    localparam int C_MATCH = 6;
    localparam int C_GOODQ = 7;
    localparam int C_NPRESENT = 8;
    localparam int C_NREAD = 9;
    localparam int C_NMATCH = 10;
    localparam int C_POORQ = 11;
    localparam int C_OVERRUN = 12;
    // ***********************************
    // register offsets
    // ***********************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_SEL0 = 8'h10;
    localparam logic [7:0] REG_ON0 = 8'h14;
    localparam logic [7:0] REG_OFF0 = 8'h18;
    localparam logic [7:0] REG_STRIDE = 8'h10;
    localparam logic [NUM_COND-1:0] SEL_RST0 = 13'h0002;
    localparam logic [NUM_COND-1:0] SEL_RST1 = 13'h0004;
    localparam logic [NUM_COND-1:0] SEL_RST2 = 13'h0008;
    localparam logic [NUM_OUT-1:0] IDLE_RST = 3'h0;
    typedef enum logic [2:0] {
        RRPO_IDLE = 3'b001,
        RRPO_ON = 3'b010,
        RRPO_OFF = 3'b100
    } rrpo_state_t;
endpackage : rrpo_pkg

// [core/rrpo_tick.sv]
// rrpo_tick: one microsecond tick generator
`timescale 1ns/1ps
`default_nettype none
module rrpo_tick #(
    parameter int DIV = rrpo_pkg::TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    output logic tick_o
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } rrpo_tick_st_t;
    rrpo_tick_st_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == 8'(DIV - 1)) begin
            s_d.cnt = 8'h00;
            s_d.tick = 1'b1; // RL25
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign tick_o = s_q.tick;
    a_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_o |-> s_q.cnt == 8'h00 ##1 !tick_o) else $error("tick too frequent"); // RL25
endmodule : rrpo_tick
`default_nettype wire

// [core/rrpo_pulse.sv]
// rrpo_pulse: one pulsed output channel
`timescale 1ns/1ps
`default_nettype none
module rrpo_pulse #(
    parameter int TW = rrpo_pkg::TIME_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic fire_i,
    input wire logic idle_i,
    input wire logic [TW-1:0] on_us_i,
    input wire logic [TW-1:0] off_us_i,
    output logic pin_o,
    output logic busy_o
);
    typedef struct packed {
        rrpo_pkg::rrpo_state_t st;
        logic [TW-1:0] cnt;
        logic act;
    } rrpo_pulse_st_t;
    rrpo_pulse_st_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        unique case (s_q.st)
            rrpo_pkg::RRPO_IDLE: begin
                if (fire_i) begin
                    s_d.cnt = '0;
                    s_d.st = (on_us_i == '0) ? rrpo_pkg::RRPO_OFF : rrpo_pkg::RRPO_ON; // RL2 RL9
                    s_d.act = (on_us_i != '0);
                end
            end
            rrpo_pkg::RRPO_ON: begin
                if (tick_i) begin
                    s_d.cnt = s_q.cnt + 1'b1; // RL7
                    if (s_q.cnt + 1'b1 >= on_us_i) begin
                        s_d.cnt = '0;
                        s_d.st = rrpo_pkg::RRPO_OFF;
                        s_d.act = 1'b0;
                    end
                end
            end
            rrpo_pkg::RRPO_OFF: begin
                if (off_us_i == '0) begin
                    s_d.st = rrpo_pkg::RRPO_IDLE;
                end else if (tick_i) begin
                    s_d.cnt = s_q.cnt + 1'b1; // RL8
                    if (s_q.cnt + 1'b1 >= off_us_i) begin
                        s_d.st = rrpo_pkg::RRPO_IDLE;
                    end
                end
            end
            default: begin
                s_d.st = rrpo_pkg::RRPO_IDLE;
                s_d.act = 1'b0;
            end
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '{st: rrpo_pkg::RRPO_IDLE, cnt: '0, act: 1'b0}; // RL24
        end else begin
            s_q <= s_d;
        end
    end
    assign pin_o = s_q.act ^ idle_i; // RL4
    assign busy_o = (s_q.st != rrpo_pkg::RRPO_IDLE) || fire_i;
    a_act_only_on: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.act |-> s_q.st == rrpo_pkg::RRPO_ON) else $error("active outside on phase"); // RL2
    a_idle_level: assert property (@(posedge clk_i) disable iff (rst_i)
        s_q.st != rrpo_pkg::RRPO_ON |-> pin_o == idle_i) else $error("pin not at idle level"); // RL4
endmodule : rrpo_pulse
`default_nettype wire

// [core/rrpo_top.sv]
// rrpo_top: three pulsed read result outputs with wishbone registers
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rrpo_top #(
    parameter int NO = rrpo_pkg::NUM_OUT,
    parameter int NC = rrpo_pkg::NUM_COND,
    parameter int TW = rrpo_pkg::TIME_W,
    parameter int TDIV = rrpo_pkg::TICK_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cycle_end_i,
    input wire logic data_sent_i,
    input wire logic trigger_i,
    input wire logic acq_done_i,
    input wire logic buf_empty_i,
    input wire logic fault_i,
    input wire logic match_en_i,
    input wire logic [7:0] roi_en_i,
    input wire logic [7:0] roi_found_i,
    input wire logic [7:0] roi_qual_i,
    input wire logic [7:0] roi_match_i,
    input wire logic [7:0] roi_verify_en_i,
    input wire logic [7:0] roi_verify_ok_i,
    output logic [NO-1:0] out_pin_o,
    output logic cycle_busy_o,
    output logic cycle_done_o
);
    // ***********************************
    // state
    // ***********************************
    typedef struct packed {
        logic [NO-1:0][NC-1:0] sel;
        logic [NO-1:0][TW-1:0] on_us;
        logic [NO-1:0][TW-1:0] off_us;
        logic [NO-1:0] idle;
        logic acq_busy;
        logic trig_ovr;
        logic proc_ovr;
        logic gen_fault;
        logic wait_data;
        logic pend;
        logic [NC-1:0] cond;
        logic [NO-1:0] fire;
        logic done;
        logic ack;
        logic [31:0] rdat;
    } rrpo_top_st_t;
    rrpo_top_st_t s_q, s_d;
    logic tick;
    logic [NO-1:0] busy;
    logic [NC-1:0] cond_now;
    logic all_present, all_read, all_match, good_q, any_busy;
    function automatic logic [TW-1:0] clip_time(input logic [31:0] v);
        if (v > 32'(rrpo_pkg::TIME_MAX_US)) begin
            clip_time = rrpo_pkg::TIME_MAX_US;
        end else begin
            clip_time = v[TW-1:0];
        end
    endfunction : clip_time
    // ***********************************
    // result conditions
    // ***********************************
    always_comb begin
        all_present = ((roi_found_i & roi_en_i) == roi_en_i); // RL14
        all_read = all_present && ((roi_qual_i & roi_en_i) == roi_en_i); // RL15
        all_match = all_read && (!match_en_i || ((roi_match_i & roi_en_i) == roi_en_i)); // RL16 RL23
        good_q = ((roi_verify_ok_i & roi_verify_en_i & roi_qual_i) == (roi_verify_en_i & roi_qual_i)); // RL22
        cond_now = '0;
        cond_now[rrpo_pkg::C_PASS] = all_match; // RL11
        cond_now[rrpo_pkg::C_FAIL] = !all_match; // RL12
        cond_now[rrpo_pkg::C_PRESENT] = all_present;
        cond_now[rrpo_pkg::C_READ] = all_read;
        cond_now[rrpo_pkg::C_MATCH] = all_match;
        cond_now[rrpo_pkg::C_GOODQ] = good_q;
        cond_now[rrpo_pkg::C_NPRESENT] = !all_present; // RL17
        cond_now[rrpo_pkg::C_NREAD] = all_present && !all_read; // RL18
        cond_now[rrpo_pkg::C_NMATCH] = all_read && !all_match; // RL19
        cond_now[rrpo_pkg::C_POORQ] = !good_q;
        cond_now[rrpo_pkg::C_OVERRUN] = s_q.trig_ovr || s_q.proc_ovr || trigger_i && (s_q.acq_busy || buf_empty_i);
        cond_now[rrpo_pkg::C_ERROR] = cond_now[rrpo_pkg::C_OVERRUN] || s_q.gen_fault || fault_i; // RL13
    end
    // ***********************************
    // sequencing and registers
    // ***********************************
    always_comb begin
        logic [7:0] base;
        base = 8'h00;
        s_d = s_q;
        s_d.fire = '0;
        s_d.done = 1'b0;
        s_d.ack = 1'b0;
        if (trigger_i && s_q.acq_busy) begin
            s_d.trig_ovr = 1'b1; // RL20
        end
        if (trigger_i && buf_empty_i) begin
            s_d.proc_ovr = 1'b1; // RL21
        end
        if (fault_i) begin
            s_d.gen_fault = 1'b1;
        end
        if (trigger_i) begin
            s_d.acq_busy = 1'b1;
        end else if (acq_done_i) begin
            s_d.acq_busy = 1'b0;
        end
        if (cycle_end_i && !s_q.wait_data && !s_q.pend) begin
            s_d.cond = cond_now;
            s_d.wait_data = 1'b1;
            for (int i = 0; i < NO; i++) begin
                s_d.fire[i] = |(cond_now & s_q.sel[i] & ~(NC'(1) << rrpo_pkg::C_COMPLETE)); // RL5 RL2
            end
            s_d.trig_ovr = 1'b0;
            s_d.proc_ovr = 1'b0;
            s_d.gen_fault = 1'b0;
        end
        if (s_q.wait_data && data_sent_i) begin
            s_d.wait_data = 1'b0;
            s_d.pend = 1'b1;
            for (int i = 0; i < NO; i++) begin
                s_d.fire[i] = s_q.sel[i][rrpo_pkg::C_COMPLETE]; // RL10
            end
        end
        if (s_q.pend && !any_busy && s_q.fire == '0) begin
            s_d.pend = 1'b0;
            s_d.done = 1'b1; // RL3
        end
        if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
            s_d.ack = 1'b1;
            s_d.rdat = 32'h0000_0000;
            if (wb_adr_i == rrpo_pkg::REG_CTRL) begin
                s_d.rdat = 32'(s_q.idle);
                if (wb_we_i && wb_sel_i[0]) begin
                    s_d.idle = wb_dat_i[NO-1:0]; // RL4
                end
            end else if (wb_adr_i == rrpo_pkg::REG_STAT) begin
                s_d.rdat = {24'h00_0000, 1'b0, s_q.pend, s_q.wait_data, any_busy, busy, s_q.trig_ovr | s_q.proc_ovr};
            end
            for (int i = 0; i < NO; i++) begin
                base = 8'(i) * rrpo_pkg::REG_STRIDE;
                if (wb_adr_i == rrpo_pkg::REG_SEL0 + base) begin
                    s_d.rdat = 32'(s_q.sel[i]);
                    if (wb_we_i && wb_sel_i[1:0] == 2'b11) begin
                        s_d.sel[i] = wb_dat_i[NC-1:0]; // RL1
                    end
                end
                if (wb_adr_i == rrpo_pkg::REG_ON0 + base) begin
                    s_d.rdat = 32'(s_q.on_us[i]);
                    if (wb_we_i && wb_sel_i == 4'hF) begin
                        s_d.on_us[i] = clip_time(wb_dat_i); // RL7
                    end
                end
                if (wb_adr_i == rrpo_pkg::REG_OFF0 + base) begin
                    s_d.rdat = 32'(s_q.off_us[i]);
                    if (wb_we_i && wb_sel_i == 4'hF) begin
                        s_d.off_us[i] = clip_time(wb_dat_i); // RL8
                    end
                end
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.sel[0] <= rrpo_pkg::SEL_RST0; // RL6
            s_q.sel[1] <= rrpo_pkg::SEL_RST1;
            s_q.sel[2] <= rrpo_pkg::SEL_RST2;
            s_q.idle <= rrpo_pkg::IDLE_RST;
            for (int i = 0; i < NO; i++) begin
                s_q.on_us[i] <= rrpo_pkg::TIME_DEF_US;
                s_q.off_us[i] <= rrpo_pkg::TIME_DEF_US;
            end
        end else begin
            s_q <= s_d;
        end
    end
    // ***********************************
    // channels
    // ***********************************
    rrpo_tick #(.DIV(TDIV)) u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );
    for (genvar g = 0; g < NO; g++) begin : g_ch
        rrpo_pulse #(.TW(TW)) u_pulse (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tick_i(tick),
            .fire_i(s_q.fire[g]),
            .idle_i(s_q.idle[g]),
            .on_us_i(s_q.on_us[g]),
            .off_us_i(s_q.off_us[g]),
            .pin_o(out_pin_o[g]),
            .busy_o(busy[g])
        );
    end
    assign any_busy = |busy;
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdat;
    assign cycle_busy_o = s_q.wait_data | s_q.pend;
    assign cycle_done_o = s_q.done;
    // ***********************************
    // checks
    // ***********************************
    a_done_needs_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        cycle_done_o |-> $past(!any_busy)) else $error("cycle done while pulsing"); // RL3
    a_fire_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        cycle_end_i && !cycle_busy_o && s_q.sel[0] == rrpo_pkg::SEL_RST0 && all_match
        |=> s_q.fire[0]) else $error("pass did not fire"); // RL11
    a_fail_excl: assert property (@(posedge clk_i) disable iff (rst_i)
        cond_now[rrpo_pkg::C_PASS] != cond_now[rrpo_pkg::C_FAIL] && cond_now[rrpo_pkg::C_FAIL] ==
        ((roi_found_i & roi_en_i) != roi_en_i || (roi_qual_i & roi_en_i) != roi_en_i
        || match_en_i && (roi_match_i & roi_en_i) != roi_en_i)) else $error("pass and fail overlap"); // RL12
    a_match_nomatch: assert property (@(posedge clk_i) disable iff (rst_i)
        !match_en_i && all_read |-> all_match) else $error("match not assumed"); // RL23
    a_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held"); // RL1
    a_reset_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> out_pin_o == s_q.idle) else $error("not idle after reset"); // RL24
    a_ovr_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        trigger_i && s_q.acq_busy && !(cycle_end_i && !cycle_busy_o) |=> s_q.trig_ovr) else $error("overrun lost"); // RL20
    a_ovr_proc: assert property (@(posedge clk_i) disable iff (rst_i)
        trigger_i && buf_empty_i && !(cycle_end_i && !cycle_busy_o) |=> s_q.proc_ovr) else $error("proc overrun lost"); // RL21
    c_pulse: cover property (@(posedge clk_i) s_q.fire[0] ##[1:20] cycle_done_o);
    c_complete: cover property (@(posedge clk_i) s_q.wait_data && data_sent_i);
    c_error: cover property (@(posedge clk_i) s_q.fire[2]);
endmodule : rrpo_top
`default_nettype wire

// [bench/rrpo_host_model.sv]
// rrpo_host_model: host that watches the three result output lines
`timescale 1ns/1ps
`default_nettype none
module rrpo_host_model (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic [2:0] idle_i,
    input wire logic [2:0] pin_i
);
    int cnt[3];
    int run[3];
    int wid[3];
    time t_act[3];
    // ***********************************
    // pulse counting and width capture
    // ***********************************
    always @(posedge clk_i) begin
        for (int i = 0; i < 3; i++) begin
            if (clr_i) begin
                cnt[i] = 0;
                wid[i] = 0;
            end
            // active means away from the idle level
            if (pin_i[i] !== idle_i[i]) begin
                if (run[i] == 0) begin
                    cnt[i]++;
                    t_act[i] = $time;
                end
                run[i]++;
            end else begin
                if (run[i] != 0) wid[i] = run[i];
                run[i] = 0;
            end
        end
    end
endmodule : rrpo_host_model
`default_nettype wire

// [bench/tb_rrpo_top.sv]
// tb_rrpo_top: self-checking bench for the read result pulse outputs
`timescale 1ns/1ps
`default_nettype none
module tb_rrpo_top;
    localparam int TD = 2;
    localparam int ON = 3;
    localparam int OFF = 2;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic cyc_end = 1'b0, sent = 1'b0, trig = 1'b0, acq = 1'b0, flt = 1'b0, men = 1'b0, clr = 1'b0, emp = 1'b0;
    logic [7:0] fnd = 8'h00, qal = 8'h00, mat = 8'h00, vok = 8'h00;
    logic [2:0] out_pin_o;
    logic [2:0] idle = 3'h0;
    logic cycle_busy_o, cycle_done_o;
    int fails = 0;
    int num_checks = 0;
    time t_sent;
    always #4 clk_i = ~clk_i;
    rrpo_top #(.TDIV(TD)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .cycle_end_i(cyc_end), .data_sent_i(sent), .trigger_i(trig),
        .acq_done_i(acq), .buf_empty_i(emp), .fault_i(flt), .match_en_i(men), .roi_en_i(8'h03),
        .roi_found_i(fnd), .roi_qual_i(qal), .roi_match_i(mat), .roi_verify_en_i(8'h01),
        .roi_verify_ok_i(vok), .out_pin_o(out_pin_o), .cycle_busy_o(cycle_busy_o),
        .cycle_done_o(cycle_done_o));
    rrpo_host_model p_u (.clk_i(clk_i), .clr_i(clr), .idle_i(idle), .pin_i(out_pin_o));
    // ***********************************
    // compare and closing tasks
    // ***********************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input int v, input int lo, input int hi);
        num_checks++;
        if (v < lo || v > hi) begin
            fails++;
            $display("[FAIL] %0t value %0d outside %0d..%0d", $time, v, lo, hi);
        end
    endtask : chk_rng
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    // ***********************************
    // wishbone classic transfers
    // ***********************************
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= 4'hF;
        wb_dat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) chk(32'h0000_0000, 32'h0000_0001);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0000_0000, q);
        chk(q, exp);
    endtask : rd
    // ***********************************
    // one read cycle and its pulse checks
    // ***********************************
    task automatic run_cyc(input logic [7:0] f, q, m, input logic me, input logic [7:0] vk, input logic fl,
                           input logic [2:0] exp, input logic [2:0] msk);
        int len;
        logic [2:0] got;
        @(posedge clk_i);
        clr <= 1'b1;
        fnd <= f;
        qal <= q;
        mat <= m;
        men <= me;
        vok <= vk;
        flt <= fl;
        cyc_end <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        flt <= 1'b0;
        cyc_end <= 1'b0;
        @(posedge clk_i);
        chk({31'h0, cycle_busy_o}, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        sent <= 1'b1;
        t_sent = $time;
        @(posedge clk_i);
        sent <= 1'b0;
        len = 5;
        while (cycle_done_o !== 1'b1 && len < 400) begin
            @(posedge clk_i);
            len++;
        end
        repeat (2) @(posedge clk_i);
        chk({31'h0, cycle_busy_o}, 32'h0000_0000);
        for (int i = 0; i < 3; i++) got[i] = (p_u.cnt[i] == 1);
        chk({29'h0, got & msk}, {29'h0, exp & msk});
        chk_rng(len, ((exp & msk) != 3'h0) ? (ON + OFF - 1) * TD : 5, 399);
        for (int i = 0; i < 3; i++)
            if (exp[i] & msk[i]) chk_rng(p_u.wid[i], (ON - 1) * TD, ON * TD + 1);
    endtask : run_cyc
    task automatic tcase(input int c, input logic [7:0] f, q, m, input logic me, input logic [7:0] vk,
                         input logic exp);
        wr(rrpo_pkg::REG_SEL0, 32'h0000_0001 << c);
        run_cyc(f, q, m, me, vk, 1'b0, {2'b00, exp}, 3'b001);
    endtask : tcase
    // ***********************************
    // main sequence
    // ***********************************
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({29'h0, out_pin_o}, 32'h0000_0000);
        rd(rrpo_pkg::REG_CTRL, 32'h0000_0000);
        rd(rrpo_pkg::REG_STAT, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            rd(rrpo_pkg::REG_SEL0 + 8'(8'h10 * i), 32'h0000_0002 << i);
            rd(rrpo_pkg::REG_ON0 + 8'(8'h10 * i), 32'h0000_03E8);
            rd(rrpo_pkg::REG_OFF0 + 8'(8'h10 * i), 32'h0000_03E8);
        end
        rd(8'hFC, 32'h0000_0000);
        wr(rrpo_pkg::REG_ON0, 32'h00FF_FFFF);
        rd(rrpo_pkg::REG_ON0, 32'h0098_9680);
        for (int i = 0; i < 3; i++) begin
            wr(rrpo_pkg::REG_ON0 + 8'(8'h10 * i), ON);
            wr(rrpo_pkg::REG_OFF0 + 8'(8'h10 * i), OFF);
        end
        run_cyc(8'h03, 8'h03, 8'h03, 1'b1, 8'h01, 1'b0, 3'b001, 3'b111);
        run_cyc(8'h01, 8'h01, 8'h01, 1'b1, 8'h01, 1'b0, 3'b010, 3'b111);
        run_cyc(8'h03, 8'h03, 8'h03, 1'b1, 8'h01, 1'b1, 3'b101, 3'b111);
        @(posedge clk_i) trig <= 1'b1;
        @(posedge clk_i) trig <= 1'b0;
        @(posedge clk_i) trig <= 1'b1;
        @(posedge clk_i) trig <= 1'b0;
        run_cyc(8'h03, 8'h03, 8'h03, 1'b1, 8'h01, 1'b0, 3'b101, 3'b111);
        @(posedge clk_i) acq <= 1'b1;
        @(posedge clk_i) acq <= 1'b0;
        @(posedge clk_i) {emp, trig} <= 2'b11;
        @(posedge clk_i) {emp, trig} <= 2'b00;
        run_cyc(8'h03, 8'h03, 8'h03, 1'b1, 8'h01, 1'b0, 3'b101, 3'b111);
        wr(rrpo_pkg::REG_CTRL, 32'h0000_0005);
        idle <= 3'b101;
        repeat (2) @(posedge clk_i);
        chk({29'h0, out_pin_o}, 32'h0000_0005);
        run_cyc(8'h03, 8'h03, 8'h03, 1'b1, 8'h01, 1'b0, 3'b001, 3'b111);
        wr(rrpo_pkg::REG_CTRL, 32'h0000_0000);
        idle <= 3'b000;
        wr(rrpo_pkg::REG_SEL0 + 8'h20, 32'h0000_000A);
        run_cyc(8'h03, 8'h03, 8'h03, 1'b1, 8'h01, 1'b0, 3'b101, 3'b111);
        wr(rrpo_pkg::REG_SEL0 + 8'h20, 32'h0000_0008);
        tcase(rrpo_pkg::C_COMPLETE, 8'h03, 8'h03, 8'h03, 1'b1, 8'h01, 1'b1);
        chk({31'h0, p_u.t_act[0] > t_sent}, 32'h0000_0001);
        tcase(rrpo_pkg::C_PRESENT, 8'h03, 8'h03, 8'h03, 1'b1, 8'h01, 1'b1);
        tcase(rrpo_pkg::C_PRESENT, 8'h01, 8'h01, 8'h01, 1'b1, 8'h01, 1'b0);
        tcase(rrpo_pkg::C_NPRESENT, 8'h01, 8'h01, 8'h01, 1'b1, 8'h01, 1'b1);
        tcase(rrpo_pkg::C_NPRESENT, 8'h03, 8'h03, 8'h03, 1'b1, 8'h01, 1'b0);
        tcase(rrpo_pkg::C_READ, 8'h03, 8'h01, 8'h01, 1'b1, 8'h01, 1'b0);
        tcase(rrpo_pkg::C_READ, 8'h03, 8'h03, 8'h01, 1'b1, 8'h01, 1'b1);
        tcase(rrpo_pkg::C_NREAD, 8'h03, 8'h01, 8'h01, 1'b1, 8'h01, 1'b1);
        tcase(rrpo_pkg::C_MATCH, 8'h03, 8'h03, 8'h01, 1'b1, 8'h01, 1'b0);
        tcase(rrpo_pkg::C_NMATCH, 8'h03, 8'h03, 8'h01, 1'b1, 8'h01, 1'b1);
        tcase(rrpo_pkg::C_MATCH, 8'h03, 8'h03, 8'h00, 1'b0, 8'h01, 1'b1);
        tcase(rrpo_pkg::C_GOODQ, 8'h03, 8'h03, 8'h03, 1'b1, 8'h01, 1'b1);
        tcase(rrpo_pkg::C_GOODQ, 8'h03, 8'h03, 8'h03, 1'b1, 8'h00, 1'b0);
        tcase(rrpo_pkg::C_POORQ, 8'h03, 8'h03, 8'h03, 1'b1, 8'h00, 1'b1);
        end_sim();
    end
    // ***********************************
    // watchdog
    // ***********************************
    initial begin
        repeat (60000) @(posedge clk_i);
        fails++;
        end_sim();
    end
endmodule : tb_rrpo_top
`default_nettype wire
